// ==== verilog/cid_defines.svh ====
// constants for the console indicator display selector
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

// ----------------------------------------
// lamp word geometry
// ----------------------------------------
`define CID_LAMP_W       12
`define CID_LAMPS_RST    12'h000
`define CID_POS_W        3
`define CID_SW_RST       1'h0

// ----------------------------------------
// selector knob codes on the pins
// ----------------------------------------
`define CID_SEL_BUS      3'h0
`define CID_SEL_MQ       3'h1
`define CID_SEL_MD       3'h2
`define CID_SEL_AC       3'h3
`define CID_SEL_STATUS   3'h4
`define CID_SEL_STATE    3'h5
`define CID_SEL_RST      3'h0

// ----------------------------------------
// status word lamp positions
// ----------------------------------------
`define CID_ST_LINK      0
`define CID_ST_GTF       1
`define CID_ST_IRQ       2
`define CID_ST_INH       3
`define CID_ST_IEN       4
`define CID_ST_USER      5
`define CID_ST_IF_LO     6
`define CID_ST_IF_HI     8
`define CID_ST_DF_LO     9
`define CID_ST_DF_HI     11

// ----------------------------------------
// state word lamp positions
// ----------------------------------------
`define CID_SA_FETCH     0
`define CID_SA_DEFER     1
`define CID_SA_EXEC      2
`define CID_SA_IR_LO     3
`define CID_SA_IR_HI     5
`define CID_SA_MDDIR     6
`define CID_SA_BDC       7
`define CID_SA_SW        8
`define CID_SA_PIO       9
`define CID_SA_BIP       10
`define CID_SA_BCYC      11

`endif

// ==== verilog/cid_pkg.sv ====
// types shared by the console indicator display selector
package cid_pkg;

	// ----------------------------------------
	// knob positions, plus dark for unused codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		CID_POS_BUS,
		CID_POS_MQ,
		CID_POS_MD,
		CID_POS_AC,
		CID_POS_STATUS,
		CID_POS_STATE,
		CID_POS_DARK
	} cid_pos_e;

	// processor status sources
	typedef struct packed {
		logic       link;               // link bit
		logic       greater_than_flag;  // greater-than flag
		logic       irq_line;           // interrupt request line
		logic       int_inhibit;        // software interrupt block
		logic       int_enable;         // interrupt enable flip-flop
		logic       user_mode;          // user mode line
		logic [2:0] instr_field;        // instruction field register
		logic [2:0] data_field;         // data field register
	} cid_status_s;

	// machine state sources
	typedef struct packed {
		logic       fetch;                  // fetch major state
		logic       defer;                  // defer major state
		logic       execute;                // execute major state
		logic [2:0] instr_reg;              // instruction register
		logic       memory_data_direction;  // memory data direction line
		logic       break_data_continue;    // break data continue line
		logic       pause_io;               // i/o pause line
		logic       break_in_progress;      // break in progress line
		logic       break_cycle;            // break cycle line
	} cid_state_s;

	typedef logic [11:0] cid_word_t;

endpackage : cid_pkg

// ==== verilog/cid_indicator_select.sv ====
// console indicator display selector: knob, sense line and lamp word
`timescale 1ns/1ps
`default_nettype none
`include "cid_defines.svh"

module cid_indicator_select (
	input  wire logic               CLK,                      // 10 mhz processor clock
	input  wire logic               RESET,                    // async reset, active high
	input  wire logic [2:0]         SELECTOR,                 // knob code from panel pins
	input  wire logic               SENSE_SWITCH,             // sense switch pin, up is high
	input  wire cid_pkg::cid_word_t BUS_DATA,                 // data gating lines
	input  wire cid_pkg::cid_word_t MULTIPLIER_QUOTIENT_REG,  // multiplier-quotient register
	input  wire cid_pkg::cid_word_t MEMORY_BUFFER_REG,        // memory buffer register
	input  wire cid_pkg::cid_word_t ACCUMULATOR_REG,          // accumulator
	input  wire cid_pkg::cid_status_s STATUS_IN,              // status sources
	input  wire cid_pkg::cid_state_s  STATE_IN,               // machine state sources
	output logic                    SENSE_SWITCH_LINE,        // sense-switch bus line
	output cid_pkg::cid_pos_e       SELECTED_POS,             // accepted knob position
	output cid_pkg::cid_word_t      LAMPS                     // twelve lamp drivers
);
	import cid_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] sel_s1;       // first stage, read only by sel_s2
	logic [2:0] sel_s2;       // second stage
	logic [2:0] sel_s3;       // third stage
	logic       sw_s1;        // first stage, read only by sw_s2
	logic       sw_s2;        // second stage
	logic       sw_s3;        // third stage
	cid_pos_e   next_pos;     // decoded knob code
	cid_word_t  next_lamps;   // lamp word before the register
	cid_word_t  status_word;  // packed status word
	cid_word_t  state_word;   // packed machine state word

	// knob code to position; codes past the sixth leave lamps dark
	function automatic cid_pos_e decode_pos(input logic [2:0] code);
		cid_pos_e p;
		p = CID_POS_DARK;
		unique case (code)
			`CID_SEL_BUS:    p = CID_POS_BUS;
			`CID_SEL_MQ:     p = CID_POS_MQ;
			`CID_SEL_MD:     p = CID_POS_MD;
			`CID_SEL_AC:     p = CID_POS_AC;
			`CID_SEL_STATUS: p = CID_POS_STATUS;
			`CID_SEL_STATE:  p = CID_POS_STATE;
			default:         p = CID_POS_DARK; // between detents
		endcase
		return p;
	endfunction : decode_pos

	// packs the processor status lamps
	function automatic cid_word_t pack_status(input cid_status_s s);
		cid_word_t w;
		w = `CID_LAMPS_RST;
		w[`CID_ST_LINK] = s.link;
		w[`CID_ST_GTF]  = s.greater_than_flag;
		w[`CID_ST_IRQ]  = s.irq_line;
		w[`CID_ST_INH]  = s.int_inhibit;
		w[`CID_ST_IEN]  = s.int_enable;
		w[`CID_ST_USER] = s.user_mode;
		w[`CID_ST_IF_HI:`CID_ST_IF_LO] = s.instr_field;
		w[`CID_ST_DF_HI:`CID_ST_DF_LO] = s.data_field;
		return w;
	endfunction : pack_status

	// packs the machine state lamps; sense bit comes from our own line
	function automatic cid_word_t pack_state(input cid_state_s s, input logic sw);
		cid_word_t w;
		w = `CID_LAMPS_RST;
		w[`CID_SA_FETCH] = s.fetch;
		w[`CID_SA_DEFER] = s.defer;
		w[`CID_SA_EXEC]  = s.execute;
		w[`CID_SA_IR_HI:`CID_SA_IR_LO] = s.instr_reg;
		w[`CID_SA_MDDIR] = s.memory_data_direction;
		w[`CID_SA_BDC]   = s.break_data_continue;
		w[`CID_SA_SW]    = sw;
		w[`CID_SA_PIO]   = s.pause_io;
		w[`CID_SA_BIP]   = s.break_in_progress;
		w[`CID_SA_BCYC]  = s.break_cycle;
		return w;
	endfunction : pack_state

	// ----------------------------------------
	// knob input
	// ----------------------------------------
	// three stages; the knob is mechanical, so a half-seen code is held off
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sel_s1 <= `CID_SEL_RST;
			sel_s2 <= `CID_SEL_RST;
			sel_s3 <= `CID_SEL_RST;
		end else begin
			sel_s1 <= SELECTOR;
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
		end
	end

	assign next_pos = decode_pos(sel_s3);

	// position is accepted only when stages two and three agree
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			SELECTED_POS <= CID_POS_BUS;
		end else if (sel_s2 == sel_s3) begin
			SELECTED_POS <= next_pos;
		end
	end

	// ----------------------------------------
	// sense switch
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sw_s1 <= `CID_SW_RST;
			sw_s2 <= `CID_SW_RST;
			sw_s3 <= `CID_SW_RST;
		end else begin
			sw_s1 <= SENSE_SWITCH;
			sw_s2 <= sw_s1;
			sw_s3 <= sw_s2;
		end
	end

	// switch up drives the line high, down drives it low
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			SENSE_SWITCH_LINE <= `CID_SW_RST;
		end else if (sw_s2 == sw_s3) begin
			SENSE_SWITCH_LINE <= sw_s3;
		end
	end

	// ----------------------------------------
	// lamp word
	// ----------------------------------------
	assign status_word = pack_status(STATUS_IN);
	assign state_word  = pack_state(STATE_IN, SENSE_SWITCH_LINE);

	// source mux; state word only reaches lamps in the state position
	always_comb begin
		next_lamps = `CID_LAMPS_RST;
		unique case (SELECTED_POS)
			CID_POS_BUS:    next_lamps = BUS_DATA;
			CID_POS_MQ:     next_lamps = MULTIPLIER_QUOTIENT_REG;
			CID_POS_MD:     next_lamps = MEMORY_BUFFER_REG;
			CID_POS_AC:     next_lamps = ACCUMULATOR_REG;
			CID_POS_STATUS: next_lamps = status_word;
			CID_POS_STATE:  next_lamps = state_word;
			CID_POS_DARK:   next_lamps = `CID_LAMPS_RST;          // knob between detents
		endcase
	end

	// one register stage so lamps never see mux glitches; costs one cycle
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			LAMPS <= `CID_LAMPS_RST;
		end else begin
			LAMPS <= next_lamps;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	AST_KNOB_STEADY: assert property (
		(sel_s2 == sel_s3) |=> (SELECTED_POS == decode_pos($past(sel_s3))))
		else $error("knob position not taken when stages agree");

	AST_KNOB_HOLD: assert property (
		(sel_s2 != sel_s3) |=> $stable(SELECTED_POS))
		else $error("knob position moved while stages disagree");

	AST_MQ_SHOWN: assert property (
		(SELECTED_POS == CID_POS_MQ) |=> (LAMPS == $past(MULTIPLIER_QUOTIENT_REG)))
		else $error("lamps do not show multiplier-quotient register");

	AST_MD_SHOWN: assert property (
		(SELECTED_POS == CID_POS_MD) |=> (LAMPS == $past(MEMORY_BUFFER_REG)))
		else $error("lamps do not show memory buffer");

	AST_AC_SHOWN: assert property (
		(SELECTED_POS == CID_POS_AC) |=> (LAMPS == $past(ACCUMULATOR_REG)))
		else $error("lamps do not show accumulator");

	AST_STATUS_FLAGS: assert property (
		(SELECTED_POS == CID_POS_STATUS) |=>
		(LAMPS[5:0] == {$past(STATUS_IN.user_mode), $past(STATUS_IN.int_enable),
		                $past(STATUS_IN.int_inhibit), $past(STATUS_IN.irq_line),
		                $past(STATUS_IN.greater_than_flag), $past(STATUS_IN.link)}))
		else $error("status flag lamps wrong");

	AST_STATUS_FIELDS: assert property (
		(SELECTED_POS == CID_POS_STATUS) |=>
		(LAMPS[8:6] == $past(STATUS_IN.instr_field)) && (LAMPS[11:9] == $past(STATUS_IN.data_field)))
		else $error("status field lamps wrong");

	AST_STATE_MAJOR: assert property (
		(SELECTED_POS == CID_POS_STATE) |=>
		(LAMPS[2:0] == {$past(STATE_IN.execute), $past(STATE_IN.defer), $past(STATE_IN.fetch)})
		&& (LAMPS[5:3] == $past(STATE_IN.instr_reg)))
		else $error("state major and instruction lamps wrong");

	AST_STATE_LINES: assert property (
		(SELECTED_POS == CID_POS_STATE) |=>
		(LAMPS[11:6] == {$past(STATE_IN.break_cycle), $past(STATE_IN.break_in_progress),
		                 $past(STATE_IN.pause_io), $past(SENSE_SWITCH_LINE),
		                 $past(STATE_IN.break_data_continue), $past(STATE_IN.memory_data_direction)}))
		else $error("state bus line lamps wrong");

	AST_SENSE_FOLLOW: assert property (
		(sw_s2 == sw_s3) |=> (SENSE_SWITCH_LINE == $past(sw_s3)))
		else $error("sense line does not follow switch");

	AST_SENSE_PIN: assert property (
		($past(sw_s2) != sw_s2) |=> $stable(SENSE_SWITCH_LINE))
		else $error("sense line moved on a single sample");

	AST_DARK: assert property (
		(SELECTED_POS == CID_POS_DARK) |=> (LAMPS == `CID_LAMPS_RST))
		else $error("lamps lit between detents");

	AST_REGISTERED: assert property (
		$stable(next_lamps) && $stable(SELECTED_POS) |=> $stable(LAMPS))
		else $error("lamps changed without a source change");

	// ----------------------------------------
	// covers
	// ----------------------------------------
	COV_STATUS: cover property (SELECTED_POS == CID_POS_STATUS ##1 LAMPS != `CID_LAMPS_RST);
	COV_STATE:  cover property (SELECTED_POS == CID_POS_STATE ##1 LAMPS[`CID_SA_SW]);
	COV_SWAP:   cover property (SELECTED_POS == CID_POS_MQ ##[1:8] SELECTED_POS == CID_POS_AC);
	COV_SENSE:  cover property ($rose(SENSE_SWITCH_LINE));

endmodule : cid_indicator_select
`default_nettype wire

// ==== testbench/cid_panel_model.sv ====
// panel model: the selector knob and sense switch that the operator works
`timescale 1ns/1ps
`default_nettype none

module cid_panel_model (
	input  wire logic       clk,          // processor clock
	input  wire logic [2:0] knob_req,     // knob code the operator turns to
	input  wire logic       switch_req,   // sense switch wanted up
	output logic      [2:0] selector,     // knob contacts to the pins
	output logic            sense_switch  // sense switch contact
);
	// ----------------------------------------
	// contacts
	// ----------------------------------------
	// contacts settle just after an edge, so the block never sees them move at its own edge
	initial begin
		selector     = 3'h0;
		sense_switch = 1'h0;
	end

	// knob offers six positions plus unused codes switch up drives high
	always @(posedge clk) begin
		selector     <= knob_req;
		sense_switch <= switch_req;
	end
endmodule : cid_panel_model
`default_nettype wire

// ==== testbench/console_indicator_display_select_tb_top.sv ====
// testbench for the console indicator display selector
`timescale 1ns/1ps
`default_nettype none
`include "cid_defines.svh"

module console_indicator_display_select_tb_top;
	import cid_pkg::*;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic        clk = 1'h0;   // 10 mhz clock
	logic        reset = 1'h1; // held at start
	logic [2:0]  knob = 3'h0;  // wanted knob code
	logic        sw = 1'h0;    // wanted switch level
	logic [2:0]  selector;     // from panel model
	logic        sense_switch; // from panel model
	cid_word_t   bus = 12'h000, mq = 12'h000, mb = 12'h000, ac = 12'h000;
	cid_status_s st = '0;      // status sources
	cid_state_s  sa = '0;      // state sources
	logic        sense_line;   // sense bus line out
	cid_pos_e    pos;          // accepted position
	cid_word_t   lamps;        // lamp word
	cid_word_t   want;         // expected lamp word
	integer      seed = 32'h0885d7fd;
	int          failures = 0;
	int          compares = 0;

	always #50 clk = ~clk;

	cid_panel_model cid_panel_model_inst (.clk(clk), .knob_req(knob), .switch_req(sw),
		.selector(selector), .sense_switch(sense_switch));

	cid_indicator_select cid_indicator_select_inst (.CLK(clk), .RESET(reset), .SELECTOR(selector),
		.SENSE_SWITCH(sense_switch), .BUS_DATA(bus), .MULTIPLIER_QUOTIENT_REG(mq), .MEMORY_BUFFER_REG(mb),
		.ACCUMULATOR_REG(ac), .STATUS_IN(st), .STATE_IN(sa), .SENSE_SWITCH_LINE(sense_line),
		.SELECTED_POS(pos), .LAMPS(lamps));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// lamp word for a knob code, built bit by bit rather than from the structs' own layout
	function automatic cid_word_t expect_word(input logic [2:0] p);
		case (p)
			`CID_SEL_BUS:    return bus;
			`CID_SEL_MQ:     return mq;
			`CID_SEL_MD:     return mb;
			`CID_SEL_AC:     return ac;
			`CID_SEL_STATUS: return {st.data_field, st.instr_field, st.user_mode, st.int_enable,
				st.int_inhibit, st.irq_line, st.greater_than_flag, st.link};
			`CID_SEL_STATE:  return {sa.break_cycle, sa.break_in_progress, sa.pause_io, sw,
				sa.break_data_continue, sa.memory_data_direction, sa.instr_reg, sa.execute, sa.defer, sa.fetch};
			default:         return 12'h000; // unused codes stay dark
		endcase
	endfunction : expect_word

	task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	// fresh random sources every cycle; lamps are checked 1 ns after the edge that samples them
	task automatic run(input int n, input bit chk);
		repeat (n) begin
			@(posedge clk);
			want = expect_word(knob);
			bus <= 12'($random(seed));
			mq  <= 12'($random(seed));
			mb  <= 12'($random(seed));
			ac  <= 12'($random(seed));
			st  <= cid_status_s'(12'($random(seed)));
			sa  <= cid_state_s'(11'($random(seed)));
			#1;
			if (chk) begin
				check(lamps, want, "lamp word");
			end
		end
	endtask : run

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'h0;
		// every knob code, the two unused ones included, with the switch drawn at random
		for (int p = 0; p < 8; p++) begin
			@(posedge clk);
			knob <= 3'(p);
			sw   <= 1'($random(seed));
			run(8, 0);
			check(3'(pos), (p < 6) ? 3'(p) : 3'(CID_POS_DARK), "position");
			check(12'(sense_line), 12'(sw), "sense line");
			run(20, 1);
			$display("test position %0d done", p);
		end
		// a one-sample knob bounce must not move the accepted position
		@(posedge clk);
		knob <= `CID_SEL_STATE;
		run(8, 0);
		@(posedge clk);
		knob <= `CID_SEL_MQ;
		@(posedge clk);
		knob <= `CID_SEL_STATE;
		for (int i = 0; i < 6; i++) begin
			run(1, 1);
			check(3'(pos), 3'(CID_POS_STATE), "bounce");
		end
		$display("test bounce done");
		// reset in mid-run darkens lamps and parks the knob at bus
		@(posedge clk);
		sw    <= 1'h1;
		run(6, 0);
		reset <= 1'h1;
		run(2, 0);
		check(lamps, `CID_LAMPS_RST, "reset lamps");
		check(3'(pos), 3'(CID_POS_BUS), "reset position");
		check(12'(sense_line), 12'(`CID_SW_RST), "reset sense");
		reset <= 1'h0;
		run(8, 0);
		run(10, 1);
		$display("test reset done");
		end_of_test();
	end

	// watchdog: the whole run is a few hundred cycles
	initial begin
		#200us;
		failures++;
		end_of_test();
	end
endmodule : console_indicator_display_select_tb_top
`default_nettype wire
